/* File: include/e3dl_pkg.sv */
// shared constants for the data-link message receiver tail
package e3dl_pkg;
  // register map
  localparam logic [7:0] ADDR_CONTROL      = 8'h18;
  localparam logic [7:0] ADDR_STATUS       = 8'h19;
  // control register fields
  localparam int         CTL_IRQ_FLAG_BIT  = 0;
  localparam int         CTL_IRQ_MASK_BIT  = 1;
  localparam int         CTL_RX_ON_BIT     = 2;
  localparam logic       RX_ON_RESET       = 1'b1;
  localparam logic       IRQ_MASK_RESET    = 1'b0;
  // status register fields
  localparam int         STS_FLAG_BIT      = 0;
  localparam int         STS_EOM_BIT       = 1;
  localparam int         STS_CRC_BIT       = 2;
  localparam int         STS_ORIGIN_BIT    = 3;
  localparam int         STS_KIND_LSB      = 4;
  localparam int         STS_ABORT_BIT     = 6;
  // frame layout, counted from the first octet after the opening flag
  localparam int         HDR_ORIGIN_OCTET  = 0;
  localparam int         HDR_ORIGIN_BIT    = 1;
  localparam int         PAYLOAD_FIRST     = 3;
  // message classes
  localparam logic [1:0] KIND_PATH         = 2'h0;
  localparam logic [1:0] KIND_IDLE         = 2'h1;
  localparam logic [1:0] KIND_TEST         = 2'h2;
  localparam logic [1:0] KIND_INTL_PATH    = 2'h3;
  // check sequence
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL    = 16'h8408;
  localparam logic [15:0] CRC_GOOD_RESIDUE = 16'hF0B8;
  // state machine, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_BODY   = 3'b010,
    ST_REPORT = 3'b100
  } e3dl_state_t;
endpackage

/* File: src/e3dl_fifo.sv */
// small first-word-fall-through fifo with registered output
`timescale 1ns/1ns
`default_nettype none
module e3dl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in,
  // levels
  output logic                  full_out,
  output logic                  empty_out
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two so the pointers wrap by themselves
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("e3dl_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // array pushes while room, pops into the output register
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign push         = in_valid_in && in_ready_out;
  assign pop          = (count != '0) && (!out_valid_out || out_ready_in);
  assign full_out     = !in_ready_out;
  assign empty_out    = (count == '0) && !out_valid_out;

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // output register holds the head word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem[rd_ptr];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: src/e3dl_rx_tail.sv */
// data-link message receiver tail: classify, check, report completed frames
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module e3dl_rx_tail #(
  parameter int         FIFO_DEPTH = 8,
  parameter int         ADDR_W     = 7,
  parameter logic [7:0] CODE_IDLE  = 8'h01,
  parameter logic [7:0] CODE_TEST  = 8'h02,
  parameter logic [7:0] CODE_INTL  = 8'h03
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  // destuffed octet stream from the flag search stage
  input  wire logic              octet_valid_in,
  input  wire logic [7:0]        octet_data_in,
  input  wire logic              octet_last_in,
  output logic                   octet_ready_out,
  input  wire logic              flag_present_in,
  input  wire logic              abort_in,
  output logic                   search_enable_out,
  // receive message buffer write port
  output logic                   msg_wr_valid_out,
  output logic      [ADDR_W-1:0] msg_wr_addr_out,
  output logic      [7:0]        msg_wr_data_out,
  input  wire logic              msg_wr_ready_in,
  // processor interrupt
  output logic                   irq_out
);
  // refuse a buffer address too narrow for the longest message,
  // checked at elaboration so a bad build never starts
  if (ADDR_W < 7) begin : g_addr_w_check
    $error("e3dl_rx_tail: ADDR_W must hold an 84-octet message");
  end

  // one reflected crc-16 step over an octet
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] octet);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ octet[i]) begin
        c = (c >> 1) ^ e3dl_pkg::CRC_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  // map a type octet to its two-bit class
  function automatic logic [1:0] kind_of(input logic [7:0] code);
    logic [1:0] k;
    k = e3dl_pkg::KIND_PATH;
    if (code == CODE_IDLE) begin
      k = e3dl_pkg::KIND_IDLE;
    end else if (code == CODE_TEST) begin
      k = e3dl_pkg::KIND_TEST;
    end else if (code == CODE_INTL) begin
      k = e3dl_pkg::KIND_INTL_PATH;
    end
    return k;
  endfunction

  // registers and state
  logic                    rx_on;
  logic                    irq_mask;
  logic                    irq_flag;
  logic                    eom_flag;
  logic                    crc_flag;
  logic                    origin;
  logic [1:0]              kind;
  logic                    abort_flag;
  e3dl_pkg::e3dl_state_t   state;
  e3dl_pkg::e3dl_state_t   next_state;
  logic [15:0]             crc;
  logic [ADDR_W-1:0]       octet_idx;
  logic                    frame_origin;
  logic [1:0]              frame_kind;
  logic [15:0]             frame_crc;

  // fifo wiring
  logic                    fifo_valid;
  logic [8:0]              fifo_data;
  logic                    fifo_ready;
  logic                    fifo_push;
  logic                    take;
  logic                    is_payload;
  logic                    ctl_read;
  logic                    frame_done;

  // octets only enter while the receiver is on
  // gate by receiver_on
  assign fifo_push         = octet_valid_in && rx_on;
  assign search_enable_out = rx_on;

  e3dl_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (fifo_push),
    .in_data_in    ({octet_last_in, octet_data_in}),
    .in_ready_out  (octet_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_ready),
    .full_out      (),
    .empty_out     ()
  );

  // drain stalls when the message buffer cannot take a payload octet
  assign is_payload = (octet_idx >= ADDR_W'(e3dl_pkg::PAYLOAD_FIRST));
  assign fifo_ready = (state != e3dl_pkg::ST_REPORT) && !abort_in
                      && (msg_wr_ready_in || !is_payload);
  assign take       = fifo_valid && fifo_ready;
  assign frame_done = (state == e3dl_pkg::ST_REPORT);
  assign ctl_read   = reg_rd_in && (reg_addr_in == e3dl_pkg::ADDR_CONTROL);

  // frame sequencing
  always_comb begin
    next_state = state;
    case (state)
      e3dl_pkg::ST_IDLE: begin
        if (take && !fifo_data[8]) begin
          next_state = e3dl_pkg::ST_BODY;
        end else if (take) begin
          next_state = e3dl_pkg::ST_REPORT;
        end
      end
      e3dl_pkg::ST_BODY: begin
        if (abort_in) begin
          next_state = e3dl_pkg::ST_IDLE;
        end else if (take && fifo_data[8]) begin
          next_state = e3dl_pkg::ST_REPORT;
        end
      end
      e3dl_pkg::ST_REPORT: begin
        next_state = e3dl_pkg::ST_IDLE;
      end
      default: begin
        next_state = e3dl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= e3dl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // per-frame capture: index, running crc, origin and type
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      octet_idx    <= '0;
      crc          <= e3dl_pkg::CRC_INIT;
      frame_origin <= 1'b0;
      frame_kind   <= e3dl_pkg::KIND_PATH;
    end else if (abort_in || frame_done) begin
      octet_idx    <= '0;
      crc          <= e3dl_pkg::CRC_INIT;
      frame_kind   <= e3dl_pkg::KIND_PATH;
    end else if (take) begin
      if (octet_idx != '1) begin
        octet_idx <= octet_idx + 1'b1;
      end
      crc <= crc_step(crc, fifo_data[7:0]);
      if (octet_idx == ADDR_W'(e3dl_pkg::HDR_ORIGIN_OCTET)) begin
        frame_origin <= fifo_data[e3dl_pkg::HDR_ORIGIN_BIT];
      end
      if (octet_idx == ADDR_W'(e3dl_pkg::PAYLOAD_FIRST)) begin
        frame_kind <= kind_of(fifo_data[7:0]);
      end
    end
  end

  // crc held at the end of the frame, residue checked in report
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_crc <= e3dl_pkg::CRC_INIT;
    end else if (take && fifo_data[8]) begin
      frame_crc <= crc_step(crc, fifo_data[7:0]);
    end
  end

  // payload octets go to the message buffer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msg_wr_valid_out <= 1'b0;
      msg_wr_addr_out  <= '0;
      msg_wr_data_out  <= '0;
    end else begin
      msg_wr_valid_out <= take && is_payload;
      if (take && is_payload) begin
        msg_wr_addr_out <= octet_idx - ADDR_W'(e3dl_pkg::PAYLOAD_FIRST);
        msg_wr_data_out <= fifo_data[7:0];
      end
    end
  end

  // status published in one step once the frame is fully checked
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eom_flag <= 1'b0;
      crc_flag <= 1'b0;
      origin   <= 1'b0;
      kind     <= e3dl_pkg::KIND_PATH;
    end else if (frame_done) begin
      eom_flag <= 1'b1;
      crc_flag <= (frame_crc != e3dl_pkg::CRC_GOOD_RESIDUE);
      origin   <= frame_origin;
      kind     <= frame_kind;
    end else if (take && state == e3dl_pkg::ST_IDLE) begin
      eom_flag <= 1'b0;
    end
  end

  // abort seen in any state, cleared by the next frame start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      abort_flag <= 1'b0;
    end else if (abort_in) begin
      abort_flag <= 1'b1;
    end else if (take && state == e3dl_pkg::ST_IDLE) begin
      abort_flag <= 1'b0;
    end
  end

  // control register writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_on    <= e3dl_pkg::RX_ON_RESET;
      irq_mask <= e3dl_pkg::IRQ_MASK_RESET;
    end else if (reg_wr_in && reg_addr_in == e3dl_pkg::ADDR_CONTROL) begin
      rx_on    <= reg_wdata_in[e3dl_pkg::CTL_RX_ON_BIT];
      irq_mask <= reg_wdata_in[e3dl_pkg::CTL_IRQ_MASK_BIT];
    end
  end

  // interrupt flag: set on completion wins over read clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_flag <= 1'b0;
    end else if (frame_done) begin
      irq_flag <= 1'b1;
    end else if (ctl_read) begin
      irq_flag <= 1'b0;
    end
  end

  assign irq_out = irq_flag && irq_mask;

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        e3dl_pkg::ADDR_CONTROL: begin
          reg_rdata_out <= {5'h00, rx_on, irq_mask, irq_flag};
        end
        e3dl_pkg::ADDR_STATUS: begin
          reg_rdata_out <= {1'b0, abort_flag, kind, origin, crc_flag, eom_flag,
                            flag_present_in};
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: bench/e3dl_rx_tail_asserts.sv */
// concurrent checks on the message receiver tail ports
`timescale 1ns/1ns
`default_nettype none
module e3dl_rx_tail_chk #(
  parameter int ADDR_W = 7
) (
  // clock, reset and register port
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire logic [7:0]        reg_addr_in,
  input wire logic [7:0]        reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [7:0]        reg_rdata_out,
  // stream, buffer and interrupt
  input wire logic              flag_present_in,
  input wire logic              search_enable_out,
  input wire logic              msg_wr_valid_out,
  input wire logic [ADDR_W-1:0] msg_wr_addr_out,
  input wire logic              msg_wr_ready_in,
  input wire logic              irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic              mask_sh;
  logic              on_sh;
  logic              take;
  logic [ADDR_W-1:0] last_addr;
  // octet handed to the buffer
  assign take = msg_wr_valid_out && msg_wr_ready_in;
  // shadow of the writable control bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_sh <= e3dl_pkg::IRQ_MASK_RESET;
      on_sh   <= e3dl_pkg::RX_ON_RESET;
    end else if (reg_wr_in && reg_addr_in == e3dl_pkg::ADDR_CONTROL) begin
      mask_sh <= reg_wdata_in[e3dl_pkg::CTL_IRQ_MASK_BIT];
      on_sh   <= reg_wdata_in[e3dl_pkg::CTL_RX_ON_BIT];
    end
  end
  // last buffer address handed over
  always_ff @(posedge clk_in) begin
    if (take) begin
      last_addr <= msg_wr_addr_out;
    end
  end
  sequence s_ctl_rd;
    reg_rd_in && reg_addr_in == e3dl_pkg::ADDR_CONTROL;
  endsequence
  sequence s_sts_rd;
    reg_rd_in && reg_addr_in == e3dl_pkg::ADDR_STATUS;
  endsequence
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_ctl_read_shape: assert property (s_ctl_rd |=> reg_rdata_out[7:1] == {5'h00, on_sh, mask_sh})
    else $error("control read shows wrong bits");
  a_sts_read_shape: assert property (s_sts_rd |=> !reg_rdata_out[7] && reg_rdata_out[0] == $past(flag_present_in))
    else $error("status read shows wrong flag or top bit");
  a_irq_needs_mask: assert property (irq_out |-> mask_sh)
    else $error("interrupt while masked");
  a_search_on: assert property (search_enable_out == on_sh)
    else $error("search enable differs from control bit");
  a_read_clears_irq: assert property (s_ctl_rd ##0 !take && !$past(take) && !$past(take, 2) |=> !irq_out)
    else $error("control read did not clear interrupt");
  a_irq_after_drain: assert property ($rose(irq_out) && $past(mask_sh) |-> $past(take, 2) || $past(take, 3) || $past(take, 4))
    else $error("interrupt not preceded by last buffer write");
  a_wr_addr_step: assert property (take && msg_wr_addr_out != '0 |-> msg_wr_addr_out == last_addr + 1'b1)
    else $error("buffer address skipped");
endmodule
bind e3dl_rx_tail e3dl_rx_tail_chk #(.ADDR_W(ADDR_W)) i_chk (
  .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .flag_present_in, .search_enable_out, .msg_wr_valid_out,
  .msg_wr_addr_out, .msg_wr_ready_in, .irq_out
);
`default_nettype wire

/* File: bench/e3dl_frame_src.sv */
// octet source in place of the remote sender and flag search
`timescale 1ns/1ns
`default_nettype none
module e3dl_frame_src (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // frame request
  input  wire logic       start_in,
  input  wire logic [7:0] type_in,
  input  wire logic       cr_in,
  input  wire logic       corrupt_in,
  input  wire logic       gap_in,
  output logic            busy_out,
  // octet stream
  output logic            valid_out,
  output logic [7:0]      data_out,
  output logic            last_out,
  input  wire logic       ready_in
);
  localparam int LEN = 14;
  logic [7:0]  fr [LEN];
  logic [15:0] crc;
  int          idx;
  // reflected crc-16 over one octet
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction
  // build a frame on start, then one octet per handshake
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out  <= 1'b0;
      valid_out <= 1'b0;
      last_out  <= 1'b0;
      data_out  <= 8'h5A;
    end else if (start_in && !busy_out) begin
      // command/response bit in first header octet
      fr[0] = {6'h03, cr_in, 1'b0};
      fr[1] = 8'h01;
      fr[2] = 8'h03;
      fr[3] = type_in;
      crc = 16'hFFFF;
      for (int i = 0; i < LEN - 2; i++) begin
        if (i > 3) fr[i] = 8'h10 + i[7:0];
        crc = crc8(crc, fr[i]);
      end
      crc = ~crc ^ {15'h0000, corrupt_in};
      fr[LEN-2] = crc[7:0];
      fr[LEN-1] = crc[15:8];
      idx = 0;
      busy_out  <= 1'b1;
      valid_out <= 1'b1;
      data_out  <= fr[0];
      last_out  <= 1'b0;
    end else if (busy_out) begin
      if (valid_out && ready_in) begin
        idx = idx + 1;
        valid_out <= idx < LEN && !gap_in;
        data_out  <= (idx < LEN && !gap_in) ? fr[idx] : ~data_out;
        last_out  <= idx == LEN - 1 && !gap_in;
        busy_out  <= idx < LEN;
      end else if (!valid_out) begin
        valid_out <= 1'b1;
        data_out  <= fr[idx];
        last_out  <= idx == LEN - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the message receiver tail
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam logic [7:0] CTL = e3dl_pkg::ADDR_CONTROL;
  localparam logic [7:0] STS = e3dl_pkg::ADDR_STATUS;
  logic       clk_in, rst_n_in, reg_wr_in, reg_rd_in, flag_in, abort_in, wr_rdy;
  logic       o_valid, o_last, o_ready, search_en, m_valid, irq, start, cr, bad, gap, busy;
  logic [7:0] reg_addr_in, reg_wdata_in, rdata, o_data, m_data, exp_type;
  logic [6:0] m_addr;
  int         fails, n_compared, n_wr, w0;
  logic [7:0] types [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7E};
  logic [1:0] kinds [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  e3dl_rx_tail i_dut (
    .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out(rdata), .octet_valid_in(o_valid), .octet_data_in(o_data),
    .octet_last_in(o_last), .octet_ready_out(o_ready), .flag_present_in(flag_in),
    .abort_in, .search_enable_out(search_en), .msg_wr_valid_out(m_valid),
    .msg_wr_addr_out(m_addr), .msg_wr_data_out(m_data), .msg_wr_ready_in(wr_rdy),
    .irq_out(irq)
  );
  e3dl_frame_src i_src (
    .clk_in, .rst_n_in, .start_in(start), .type_in(exp_type), .cr_in(cr),
    .corrupt_in(bad), .gap_in(gap), .busy_out(busy), .valid_out(o_valid),
    .data_out(o_data), .last_out(o_last), .ready_in(o_ready)
  );
  // clock
  always #5 clk_in = ~clk_in;
  // count buffer writes and check the type octet
  always @(posedge clk_in) begin
    if (m_valid === 1'b1 && wr_rdy === 1'b1) begin
      n_wr++;
      if (m_addr === 7'h00) `CHK("type octet", exp_type, m_data)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    @(posedge clk_in);
    `CHK(nm, e, rdata)
  endtask
  task automatic frame(input logic [7:0] t, input logic c, input logic b, input logic g);
    w0 = n_wr;
    exp_type <= t;
    cr       <= c;
    bad      <= b;
    gap      <= g;
    start    <= 1'b1;
    @(posedge clk_in);
    start    <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic settle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_in);
    // a full fifo still drains after the source stops, then report
    repeat (24) @(posedge clk_in);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    conclude();
  end
  // test sequence
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    wr_rdy = 1'b1;
    {reg_wr_in, reg_rd_in, flag_in, abort_in, start, cr, bad, gap} = '0;
    {reg_addr_in, reg_wdata_in, exp_type} = '0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rchk("control reset", CTL, 8'h04);
    rchk("status reset", STS, 8'h00);
    rchk("unmapped read", 8'h20, 8'h00);
    wr(STS, 8'hFF);
    rchk("status read only", STS, 8'h00);
    wr(CTL, 8'hFF);
    rchk("control writable", CTL, 8'h06);
    $display("test registers done");
    abort_in <= 1'b1;
    @(posedge clk_in);
    abort_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rchk("abort status", STS, 8'h40);
    rchk("abort no report", CTL, 8'h06);
    $display("test abort done");
    for (int k = 0; k < 5; k++) begin
      flag_in <= (k == 4);
      frame(types[k], k[0], k == 2, k == 3);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_in);
      `CHK("irq raised", 1'b1, irq)
      `CHK("buffer writes", 11, n_wr - w0)
      rchk("status", STS, {2'b00, kinds[k], k[0], k == 2, 1'b1, k == 4});
      rchk("irq flag", CTL, 8'h07);
      rchk("irq flag cleared", CTL, 8'h06);
      `CHK("irq dropped", 1'b0, irq)
      $display("test class %0d done", k);
    end
    flag_in <= 1'b0;
    wr(CTL, 8'h04);
    wr_rdy <= 1'b0;
    frame(8'h03, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 100 && o_ready !== 1'b0; i++) @(posedge clk_in);
    `CHK("fifo refuses", 1'b0, o_ready)
    rchk("no flag before drain", CTL, 8'h04);
    wr_rdy <= 1'b1;
    settle();
    `CHK("drained writes", 11, n_wr - w0)
    `CHK("masked irq", 1'b0, irq)
    rchk("masked flag", CTL, 8'h05);
    rchk("status intl", STS, 8'h3A);
    $display("test stall done");
    wr(CTL, 8'h00);
    `CHK("search off", 1'b0, search_en)
    frame(8'h01, 1'b0, 1'b0, 1'b0);
    settle();
    `CHK("no writes when off", 0, n_wr - w0)
    rchk("no report when off", CTL, 8'h00);
    $display("test receiver off done");
    conclude();
  end
endmodule
`default_nettype wire
